// ---- pkg/analog_handshake_pkg.sv ----
`default_nettype none
package analog_handshake_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int         NUM_POINTS = 8;
	localparam int         WORD_W     = 16;
	localparam int         CODE_W     = 12;
	localparam int         CNT_W      = 8;
	localparam int         PT_W       = 3;
	localparam int         PIN_W      = 10;
	// ----------------------------------------------------------------
	// Handshake and status word bit positions
	// ----------------------------------------------------------------
	localparam int         BIT_BUSY       = 0;
	localparam int         BIT_WR_DONE    = 1;
	localparam int         BIT_RD_DONE    = 2;
	localparam int         BIT_UNCONF     = 3;
	localparam int         BIT_ZERO_LO    = 4;
	localparam int         BIT_PEAK_RESET = 7;
	localparam int         BIT_PEAK_BASE  = 8;
	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [7:0]  MAX_XFER_WORDS  = 8'hFF;
	localparam logic [7:0]  POINT_LIMIT     = 8'h08;
	localparam logic [7:0]  USED_MASK_RESET = 8'hFF;
	localparam logic [11:0] CODE_MIN        = 12'h000;
	localparam logic [11:0] CODE_MAX        = 12'hFFF;
	// Levels are in millivolts: 1 V offset and 5 V gain.
	localparam logic [15:0] DEFAULT_OFFSET  = 16'h03E8;
	localparam logic [15:0] DEFAULT_GAIN    = 16'h1388;
	localparam logic [2:0]  SETTLE_CYCLES   = 3'h4;
	localparam logic [3:0]  ZERO_NIBBLE     = 4'h0;

	typedef enum logic [1:0] {
		XF_IDLE,
		XF_WRITE,
		XF_FETCH,
		XF_SEND
	} xfer_state_t;
endpackage : analog_handshake_pkg
`default_nettype wire

// ---- design/code_store.sv ----
`timescale 1ns/1ps
`default_nettype none
module code_store #(
	parameter int AW = 3,
	parameter int DW = 12
) (
	input  wire logic          CLK,
	input  wire logic          RESET_N,
	input  wire logic          WE,
	input  wire logic [AW-1:0] WADDR,
	input  wire logic [DW-1:0] WDATA,
	input  wire logic [AW-1:0] RADDR,
	output var  logic [DW-1:0] RDATA
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge CLK) begin
		if (WE) begin
			mem[WADDR] <= WDATA;
		end
	end

	// Read data is registered so the caller sees one cycle of latency.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RDATA <= '0;
		end else begin
			RDATA <= mem[RADDR];
		end
	end
endmodule : code_store
`default_nettype wire

// ---- design/analog_input_host_handshake.sv ----
// Summary of operation
// [R1] Word mode switch selects two-word or four-word allocation.
// [R2] Mode switch sampled once after power-up, later changes ignored.
// [R3] Four-word mode moves data only at scan refresh, no block transfers.
// [R4] Host picks four-word mode without block instructions or on old racks.
// [R5] Every point defaults to 1 V offset and 5 V gain.
// [R6] Operator selects exactly one point pin during calibration.
// [R7] Toggle down captures selected point level as offset, code 000.
// [R8] Toggle up captures selected point level as gain, code FFF.
// [R9] Block write runs only when busy and read-done are clear.
// [R10] Write completion pulses once and raises the equal flag.
// [R11] Block read runs only when busy clear and write-done set.
// [R12] Host never issues read and write together; write goes first.
// [R13] Host repeats transfers every scan on newer remote racks.
// [R14] Remote master serves two transfers; a third sets carry.
// [R15] One block transfer carries at most 255 words.
// [R16] Busy, write-done, read-done sit in bits 0, 1, 2.
// [R17] Control bit 7 is peak reset; status bit 3 unconfirmed data.
// [R18] Bits 8 to 15 are per-point peak read requests and peak flags.
// [R19] Unconfirmed flag stays up until converted values are valid.
// [R20] Peak reset with peak read bits clears those stored peaks.
// [R21] Peak flag rises when a point reaches a new peak value.
// [R22] Module read-complete is reported in status bit 2.
`timescale 1ns/1ps
`default_nettype none
module analog_input_host_handshake (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        WORD_MODE_SW,
	input  wire logic [7:0]  POINT_SELECT_PINS,
	input  wire logic        CALIBRATION_TOGGLE,
	input  wire logic        SMP_VALID,
	input  wire logic [2:0]  SMP_POINT,
	input  wire logic [15:0] SMP_LEVEL,
	input  wire logic [11:0] SMP_CODE,
	input  wire logic [15:0] HOST_HANDSHAKE_WORD,
	input  wire logic        WR_REQ,
	input  wire logic        RD_REQ,
	input  wire logic [7:0]  XFER_COUNT,
	input  wire logic        WR_STB,
	input  wire logic [15:0] WR_DATA,
	input  wire logic        IO_REFRESH,
	input  wire logic [2:0]  CAL_POINT,
	output var  logic [15:0] MODULE_STATUS_WORD,
	output var  logic        FOUR_WORD_MODE,
	output var  logic        EQUAL_FLAG,
	output var  logic        XFER_NOP,
	output var  logic        RD_VALID,
	output var  logic [15:0] RD_DATA,
	output var  logic [2:0]  MOVE_POINT,
	output var  logic [11:0] MOVE_CODE,
	output var  logic [15:0] CAL_OFFSET,
	output var  logic [15:0] CAL_GAIN
);
	localparam int NP = analog_handshake_pkg::NUM_POINTS;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [9:0] sync1_ff, sync2_ff, sync3_ff, stable_ff;
	logic [9:0] pin_agree;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else begin
			sync1_ff <= {CALIBRATION_TOGGLE, POINT_SELECT_PINS, WORD_MODE_SW};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	assign pin_agree = ~(sync2_ff ^ sync3_ff);

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			stable_ff <= '0;
		end else begin
			stable_ff <= (sync2_ff & pin_agree) | (stable_ff & ~pin_agree);
		end
	end

	// ----------------------------------------------------------------
	// Power-up mode capture
	// ----------------------------------------------------------------
	logic [2:0] settle_ff;
	logic       started_ff;
	logic       mode_ff;

	// Waiting for the synchroniser to fill keeps reset zeros out of mode.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			settle_ff  <= '0;
			started_ff <= 1'b0;
			mode_ff    <= 1'b0;
		end else if (!started_ff) begin
			settle_ff <= settle_ff + 3'h1;
			if (settle_ff == analog_handshake_pkg::SETTLE_CYCLES) begin
				started_ff <= 1'b1;
				mode_ff    <= stable_ff[0]; // [R1] [R2]
			end
		end
	end

	// ----------------------------------------------------------------
	// Calibration capture
	// ----------------------------------------------------------------
	logic        toggle_prev_ff;
	logic        cap_pending_ff;
	logic        cap_gain_ff;
	logic [2:0]  cap_pt_ff;
	logic        toggle_edge;
	logic        cap_hit;
	logic [15:0] offset_ff [NP];
	logic [15:0] gain_ff   [NP];

	function automatic logic [2:0] sel_index(input logic [7:0] s);
		logic [2:0] r;
		r = 3'h0;
		for (int k = 0; k < 8; k++) begin
			if (s[k]) begin
				r = 3'(k);
			end
		end
		return r;
	endfunction : sel_index

	assign toggle_edge = started_ff && (stable_ff[9] != toggle_prev_ff);
	assign cap_hit = cap_pending_ff && SMP_VALID && (SMP_POINT == cap_pt_ff);

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			toggle_prev_ff <= 1'b0;
			cap_pending_ff <= 1'b0;
			cap_gain_ff    <= 1'b0;
			cap_pt_ff      <= '0;
		end else begin
			toggle_prev_ff <= stable_ff[9];
			// A level on more than one pin is ignored as operator error.
			if (toggle_edge && !cap_pending_ff && $onehot(stable_ff[8:1])) begin // [R6]
				cap_pending_ff <= 1'b1;
				cap_gain_ff    <= stable_ff[9];
				cap_pt_ff      <= sel_index(stable_ff[8:1]);
			end else if (cap_hit) begin
				cap_pending_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-point peak and calibration state
	// ----------------------------------------------------------------
	logic [11:0] peak_ff [NP];
	logic [7:0]  peak_flag_ff;
	logic [7:0]  seen_ff;

	for (genvar i = 0; i < NP; i++) begin : g_point
		logic hit;
		logic peak_clr;
		assign hit = SMP_VALID && (SMP_POINT == 3'(i));
		assign peak_clr = HOST_HANDSHAKE_WORD[analog_handshake_pkg::BIT_PEAK_RESET]
			&& HOST_HANDSHAKE_WORD[analog_handshake_pkg::BIT_PEAK_BASE + i];

		// A new peak in the clearing cycle wins over the clear.
		always_ff @(posedge CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				peak_ff[i]      <= analog_handshake_pkg::CODE_MIN;
				peak_flag_ff[i] <= 1'b0;
			end else if (hit && (SMP_CODE > peak_ff[i])) begin
				peak_ff[i]      <= SMP_CODE; // [R21]
				peak_flag_ff[i] <= 1'b1;
			end else if (peak_clr) begin
				peak_ff[i]      <= analog_handshake_pkg::CODE_MIN; // [R20]
				peak_flag_ff[i] <= 1'b0;
			end
		end

		always_ff @(posedge CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				offset_ff[i] <= analog_handshake_pkg::DEFAULT_OFFSET; // [R5]
				gain_ff[i]   <= analog_handshake_pkg::DEFAULT_GAIN;
			end else if (cap_hit && (cap_pt_ff == 3'(i))) begin
				if (cap_gain_ff) begin
					gain_ff[i] <= SMP_LEVEL; // [R8]
				end else begin
					offset_ff[i] <= SMP_LEVEL; // [R7]
				end
			end
		end

		always_ff @(posedge CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				seen_ff[i] <= 1'b0;
			end else if (hit && started_ff) begin
				seen_ff[i] <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CAL_OFFSET <= analog_handshake_pkg::DEFAULT_OFFSET;
			CAL_GAIN   <= analog_handshake_pkg::DEFAULT_GAIN;
		end else begin
			CAL_OFFSET <= offset_ff[CAL_POINT];
			CAL_GAIN   <= gain_ff[CAL_POINT];
		end
	end

	// ----------------------------------------------------------------
	// Converted code store and scan-refreshed move data
	// ----------------------------------------------------------------
	logic [11:0] mem_rdata;
	logic [7:0]  idx_ff;

	code_store #(
		.AW (analog_handshake_pkg::PT_W),
		.DW (analog_handshake_pkg::CODE_W)
	) u_store (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.WE      (SMP_VALID),
		.WADDR   (SMP_POINT),
		.WDATA   (SMP_CODE),
		.RADDR   (idx_ff[2:0]),
		.RDATA   (mem_rdata)
	);

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MOVE_POINT <= '0;
			MOVE_CODE  <= analog_handshake_pkg::CODE_MIN;
		end else if (IO_REFRESH && mode_ff && started_ff && SMP_VALID) begin
			MOVE_POINT <= SMP_POINT; // [R3]
			MOVE_CODE  <= SMP_CODE;
		end
	end

	// ----------------------------------------------------------------
	// Block transfer handshake
	// ----------------------------------------------------------------
	analog_handshake_pkg::xfer_state_t state_ff;
	logic [7:0] cnt_ff;
	logic [7:0] used_mask_ff;
	logic       wr_done_ff;
	logic       rd_done_ff;
	logic       busy;
	logic       accept_wr;
	logic       accept_rd;
	logic       host_rd_ack;

	assign busy = (state_ff != analog_handshake_pkg::XF_IDLE)
		|| cap_pending_ff || !started_ff;
	assign accept_wr = WR_REQ && !mode_ff && !busy && !rd_done_ff; // [R9]
	// Write takes priority if both requests collide.
	assign accept_rd = RD_REQ && !mode_ff && !busy && wr_done_ff
		&& !accept_wr; // [R11] [R12]
	assign host_rd_ack =
		HOST_HANDSHAKE_WORD[analog_handshake_pkg::BIT_RD_DONE];

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff     <= analog_handshake_pkg::XF_IDLE;
			cnt_ff       <= '0;
			idx_ff       <= '0;
			used_mask_ff <= analog_handshake_pkg::USED_MASK_RESET;
			wr_done_ff   <= 1'b0;
			rd_done_ff   <= 1'b0;
			EQUAL_FLAG   <= 1'b0;
			XFER_NOP     <= 1'b0;
			RD_VALID     <= 1'b0;
			RD_DATA      <= '0;
		end else begin
			EQUAL_FLAG <= 1'b0;
			RD_VALID   <= 1'b0;
			XFER_NOP   <= (WR_REQ && !accept_wr) || (RD_REQ && !accept_rd);
			unique case (state_ff)
				analog_handshake_pkg::XF_IDLE: begin
					cnt_ff <= XFER_COUNT; // [R15]
					idx_ff <= '0;
					if (accept_wr) begin
						state_ff <= analog_handshake_pkg::XF_WRITE;
					end else if (accept_rd) begin
						state_ff <= analog_handshake_pkg::XF_FETCH;
					end else if (host_rd_ack) begin
						rd_done_ff <= 1'b0;
					end
				end
				analog_handshake_pkg::XF_WRITE: begin
					if (cnt_ff == '0) begin
						EQUAL_FLAG <= 1'b1; // [R10]
						wr_done_ff <= 1'b1;
						state_ff   <= analog_handshake_pkg::XF_IDLE;
					end else if (WR_STB) begin
						if (idx_ff == '0) begin
							used_mask_ff <= WR_DATA[7:0];
						end
						cnt_ff <= cnt_ff - 8'h01;
						idx_ff <= idx_ff + 8'h01;
					end
				end
				analog_handshake_pkg::XF_FETCH: begin
					if (cnt_ff == '0) begin
						EQUAL_FLAG <= 1'b1;
						rd_done_ff <= 1'b1; // [R22]
						wr_done_ff <= 1'b0;
						state_ff   <= analog_handshake_pkg::XF_IDLE;
					end else begin
						state_ff <= analog_handshake_pkg::XF_SEND;
					end
				end
				analog_handshake_pkg::XF_SEND: begin
					RD_VALID <= 1'b1;
					if (idx_ff >= analog_handshake_pkg::POINT_LIMIT) begin
						RD_DATA <= '0;
					end else if (HOST_HANDSHAKE_WORD[
						analog_handshake_pkg::BIT_PEAK_BASE + idx_ff[2:0]]) begin
						RD_DATA <= {4'h0, peak_ff[idx_ff[2:0]]}; // [R18]
					end else begin
						RD_DATA <= {4'h0, mem_rdata};
					end
					cnt_ff   <= cnt_ff - 8'h01;
					idx_ff   <= idx_ff + 8'h01;
					state_ff <= analog_handshake_pkg::XF_FETCH;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MODULE_STATUS_WORD <= '0;
			MODULE_STATUS_WORD[analog_handshake_pkg::BIT_BUSY]   <= 1'b1;
			MODULE_STATUS_WORD[analog_handshake_pkg::BIT_UNCONF] <= 1'b1;
			FOUR_WORD_MODE <= 1'b0;
		end else begin
			MODULE_STATUS_WORD <= {peak_flag_ff, analog_handshake_pkg::ZERO_NIBBLE,
				!(&(seen_ff | ~used_mask_ff)), rd_done_ff, wr_done_ff,
				busy}; // [R16] [R17] [R18] [R19]
			FOUR_WORD_MODE <= mode_ff;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	sequence write_ends;
		state_ff == analog_handshake_pkg::XF_WRITE && cnt_ff == '0;
	endsequence
	sequence done_pulse;
		EQUAL_FLAG && wr_done_ff ##1 !EQUAL_FLAG;
	endsequence

	AST_MODE_HELD: assert property ( // [R2]
		started_ff && $past(started_ff) |-> $stable(mode_ff))
		else $error("Word mode changed after power-up.");
	AST_WR_NOP: assert property ( // [R9]
		WR_REQ && (busy || rd_done_ff) |=> XFER_NOP
		&& (state_ff != analog_handshake_pkg::XF_WRITE
		|| $past(state_ff) == analog_handshake_pkg::XF_WRITE))
		else $error("Block write not refused.");
	AST_WR_DONE: assert property ( // [R10]
		write_ends |=> done_pulse)
		else $error("Write completion pulse wrong.");
	AST_RD_NOP: assert property ( // [R11]
		RD_REQ && !WR_REQ && !wr_done_ff |=> XFER_NOP
		&& state_ff == analog_handshake_pkg::XF_IDLE)
		else $error("Block read not refused.");
	AST_FOUR_IDLE: assert property ( // [R3]
		started_ff && mode_ff |-> state_ff == analog_handshake_pkg::XF_IDLE)
		else $error("Block transfer in four-word mode.");
	AST_DEFAULT_CAL: assert property ( // [R5]
		!started_ff |=> CAL_OFFSET == analog_handshake_pkg::DEFAULT_OFFSET
		&& CAL_GAIN == analog_handshake_pkg::DEFAULT_GAIN)
		else $error("Calibration defaults wrong.");
	AST_CAP_GAIN: assert property ( // [R8]
		cap_hit && cap_gain_ff |=> gain_ff[$past(cap_pt_ff)] == $past(SMP_LEVEL))
		else $error("Gain not captured.");
	AST_CAP_OFFSET: assert property ( // [R7]
		cap_hit && !cap_gain_ff
		|=> offset_ff[$past(cap_pt_ff)] == $past(SMP_LEVEL))
		else $error("Offset not captured.");
	AST_PEAK_CLEAR: assert property ( // [R20]
		g_point[0].peak_clr && !(g_point[0].hit && SMP_CODE > peak_ff[0])
		|=> !peak_flag_ff[0] && peak_ff[0] == analog_handshake_pkg::CODE_MIN)
		else $error("Peak not cleared.");
	AST_STATUS_LAYOUT: assert property ( // [R17]
		##1 MODULE_STATUS_WORD[7:4] == analog_handshake_pkg::ZERO_NIBBLE
		&& MODULE_STATUS_WORD[analog_handshake_pkg::BIT_RD_DONE]
		== $past(rd_done_ff))
		else $error("Status layout wrong.");
	AST_UNCONF_START: assert property ( // [R19]
		!started_ff |=> MODULE_STATUS_WORD[analog_handshake_pkg::BIT_UNCONF])
		else $error("Unconfirmed flag low at start.");
endmodule : analog_input_host_handshake
`default_nettype wire

// ---- test/host_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
	input  wire logic        clk,
	input  wire logic        equal_flag,
	input  wire logic        xfer_nop,
	input  wire logic        rd_valid,
	input  wire logic [15:0] rd_data,
	output var  logic [15:0] host_word,
	output var  logic        wr_req,
	output var  logic        rd_req,
	output var  logic [7:0]  xfer_count,
	output var  logic        wr_stb,
	output var  logic [15:0] wr_data
);
	// ----------------------------------------------------------------
	// Host side of the block transfers
	// ----------------------------------------------------------------
	// Result: 0 no answer, 1 done, 2 refused.
	logic [15:0] rd_buf [0:254];
	int          rd_cnt;
	initial begin
		host_word  = 16'h0000;
		wr_req     = 1'b0;
		rd_req     = 1'b0;
		xfer_count = 8'h00;
		wr_stb     = 1'b0;
		wr_data    = 16'h0000;
	end
	task automatic set_word(input logic [15:0] w);
		host_word <= w;
	endtask : set_word
	task automatic block_write(input logic [7:0] n,
		input logic [15:0] w0, output int res);
		int k;
		res = 0;
		@(posedge clk);
		wr_req     <= 1'b1;
		xfer_count <= n;
		for (k = 0; k < n + 40 && res == 0; k++) begin
			@(posedge clk);
			wr_req  <= 1'b0;
			wr_stb  <= (k < n);
			wr_data <= (k == 0) ? w0 : 16'h5a00 + 16'(k);
			#1;
			if (equal_flag === 1'b1) res = 1;
			else if (xfer_nop === 1'b1) res = 2;
		end
		wr_stb <= 1'b0;
		if (res == 1) begin
			// The write-done bit is a one-scan pulse, never a level.
			host_word[1] <= 1'b1;
			@(posedge clk);
			host_word[1] <= 1'b0;
		end
	endtask : block_write
	task automatic block_read(input logic [7:0] n, output int res);
		int k;
		res    = 0;
		rd_cnt = 0;
		@(posedge clk);
		rd_req     <= 1'b1;
		xfer_count <= n;
		for (k = 0; k < 2 * n + 40 && res == 0; k++) begin
			@(posedge clk);
			rd_req <= 1'b0;
			#1;
			if (rd_valid === 1'b1 && rd_cnt < 255) begin
				rd_buf[rd_cnt] = rd_data;
				rd_cnt++;
			end
			if (equal_flag === 1'b1) res = 1;
			else if (xfer_nop === 1'b1) res = 2;
		end
	endtask : block_read
endmodule : host_cpu_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, reset_n, mode_sw, toggle, smp_valid, refresh;
	logic [7:0]  pins, xfer_count;
	logic [2:0]  smp_point, cal_point, move_point;
	logic [15:0] smp_level, host_word, wr_data, status, rd_data;
	logic [15:0] cal_offset, cal_gain;
	logic [11:0] smp_code, move_code;
	logic        wr_req, rd_req, wr_stb, four_word, equal, nop, rd_valid;
	int          miscompares, comparisons, res, i;

	analog_input_host_handshake u_dut (
		.CLK(clk), .RESET_N(reset_n), .WORD_MODE_SW(mode_sw),
		.POINT_SELECT_PINS(pins), .CALIBRATION_TOGGLE(toggle),
		.SMP_VALID(smp_valid), .SMP_POINT(smp_point),
		.SMP_LEVEL(smp_level), .SMP_CODE(smp_code),
		.HOST_HANDSHAKE_WORD(host_word), .WR_REQ(wr_req),
		.RD_REQ(rd_req), .XFER_COUNT(xfer_count), .WR_STB(wr_stb),
		.WR_DATA(wr_data), .IO_REFRESH(refresh), .CAL_POINT(cal_point),
		.MODULE_STATUS_WORD(status), .FOUR_WORD_MODE(four_word),
		.EQUAL_FLAG(equal), .XFER_NOP(nop), .RD_VALID(rd_valid),
		.RD_DATA(rd_data), .MOVE_POINT(move_point),
		.MOVE_CODE(move_code), .CAL_OFFSET(cal_offset),
		.CAL_GAIN(cal_gain));
	host_cpu_model u_host (
		.clk(clk), .equal_flag(equal), .xfer_nop(nop),
		.rd_valid(rd_valid), .rd_data(rd_data), .host_word(host_word),
		.wr_req(wr_req), .rd_req(rd_req), .xfer_count(xfer_count),
		.wr_stb(wr_stb), .wr_data(wr_data));

	always #2.5 clk = ~clk;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic complete_run;
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic got(input int exp);
		if (res == 0) begin
			miscompares++;
			complete_run();
		end
		check(16'(res), 16'(exp));
	endtask : got
	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : ticks
	// A bounded wait; an answer that never comes ends the run.
	task automatic wait_idle;
		int k;
		for (k = 0; k < 200 && status[0] !== 1'b0; k++) ticks(1);
		if (status[0] !== 1'b0) begin
			miscompares++;
			complete_run();
		end
	endtask : wait_idle
	task automatic sample(input logic [2:0] p, input logic [15:0] l,
		input logic [11:0] c, input logic r);
		@(posedge clk);
		smp_valid <= 1'b1;
		smp_point <= p;
		smp_level <= l;
		smp_code  <= c;
		refresh   <= r;
		@(posedge clk);
		smp_valid <= 1'b0;
		refresh   <= 1'b0;
	endtask : sample
	task automatic do_reset(input logic m);
		@(posedge clk);
		reset_n <= 1'b0;
		mode_sw <= m;
		ticks(8);
		check(status, 16'h0009);
		check(cal_offset, 16'h03e8);
		check(cal_gain, 16'h1388);
		@(posedge clk);
		reset_n <= 1'b1;
		ticks(2);
		wait_idle();
	endtask : do_reset
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{clk, reset_n, mode_sw, toggle, smp_valid, refresh} = 6'h00;
		{pins, smp_point, cal_point, smp_level, smp_code} = 42'h0;
		miscompares = 0;
		comparisons = 0;
		do_reset(1'b0);
		check({15'h0000, four_word}, 16'h0000);
		mode_sw <= 1'b1;
		ticks(10);
		check({15'h0000, four_word}, 16'h0000);
		u_host.block_read(8'h01, res);
		got(2);
		sample(3'h0, 16'h0000, 12'h7f0, 1'b0);
		for (i = 0; i < 8; i++)
			sample(3'(i), 16'h0000, 12'h100 * 12'(i + 1), 1'b0);
		ticks(2);
		check(status, 16'hff00);
		u_host.block_write(8'h01, 16'h00ff, res);
		got(1);
		ticks(2);
		check(status, 16'hff02);
		u_host.set_word(16'h0100);
		u_host.block_read(8'hff, res);
		got(1);
		check(16'(u_host.rd_cnt), 16'h00ff);
		check(u_host.rd_buf[0], 16'h07f0);
		for (i = 1; i < 8; i++)
			check(u_host.rd_buf[i], 16'h0100 * 16'(i + 1));
		check(u_host.rd_buf[254], 16'h0000);
		ticks(2);
		check(status, 16'hff04);
		u_host.block_write(8'h01, 16'h00ff, res);
		got(2);
		u_host.set_word(16'h0004);
		ticks(4);
		u_host.set_word(16'h0000);
		ticks(2);
		check(status, 16'hff00);
		u_host.set_word(16'h0180);
		ticks(3);
		u_host.set_word(16'h0000);
		ticks(2);
		check(status, 16'hfe00);
		cal_point <= 3'h2;
		pins      <= 8'h04;
		toggle    <= 1'b1;
		ticks(6);
		sample(3'h2, 16'h1234, 12'h010, 1'b0);
		wait_idle();
		ticks(2);
		check(cal_gain, 16'h1234);
		check(cal_offset, 16'h03e8);
		toggle <= 1'b0;
		ticks(6);
		sample(3'h2, 16'h0456, 12'h010, 1'b0);
		wait_idle();
		ticks(2);
		check(cal_offset, 16'h0456);
		pins   <= 8'h06;
		toggle <= 1'b1;
		ticks(6);
		sample(3'h2, 16'h0999, 12'h010, 1'b0);
		ticks(4);
		check(cal_gain, 16'h1234);
		do_reset(1'b1);
		check({15'h0000, four_word}, 16'h0001);
		u_host.block_write(8'h01, 16'h00ff, res);
		got(2);
		sample(3'h5, 16'h0000, 12'habc, 1'b1);
		ticks(1);
		check({13'h0000, move_point}, 16'h0005);
		check({4'h0, move_code}, 16'h0abc);
		complete_run();
	end
endmodule : tb
`default_nettype wire
